// *** design/dorr_port.sv ***
// Sixteen-line digital output port with strap-controlled reset retention
`default_nettype none
module dorr_port #(
   parameter int LINES     = dorr_pkg::DORR_LINES,
   parameter int LOW_LINES = dorr_pkg::DORR_LOW_LINES
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   bus_reset,
   input  wire logic                   output_retention_strap,
   input  wire logic [LOW_LINES-1:0]   low_line_routing_strap,
   input  wire logic [3:0]             addr,
   input  wire logic [15:0]            wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [15:0]            rdata,
   output logic      [LINES-1:0]       output_header_20pin,
   output logic      [LOW_LINES-1:0]   main_connector_37pin,
   output logic                        mux_select_line_0,
   output logic                        mux_select_line_1,
   output logic                        mux_select_line_2,
   output logic                        mux_select_line_3
);
   dorr_pkg::dorr_state_e state_reg;
   dorr_pkg::dorr_state_e state_next;
   logic [LINES-1:0]     dout_reg;
   logic [LINES-1:0]     dout_next;
   logic [15:0]          rdata_reg;
   logic [15:0]          rdata_next;
   logic                 keep_sync;
   logic [LOW_LINES-1:0] route_sync;
   logic                 busrst_sync;
   logic [LOW_LINES-1:0] hdr_low;
   logic [LINES-1:0]     hdr_next;
   logic [LINES-1:0]     hdr_reg;
   logic                 wr_data;
   logic                 busrst_clear;
   logic [15:0]          strap_status;

   dorr_strap_sync #(.INIT(1'b0)) u_keep_sync (
      .clk       (clk),
      .reset     (reset),
      .pin_in    (output_retention_strap),
      .level_out (keep_sync)
   );

   dorr_strap_sync #(.INIT(1'b0)) u_busrst_sync (
      .clk       (clk),
      .reset     (reset),
      .pin_in    (bus_reset),
      .level_out (busrst_sync)
   );

   genvar gi;
   generate
      for (gi = 0; gi < LOW_LINES; gi++) begin : g_low
         logic rsync;
         dorr_strap_sync #(.INIT(1'b0)) u_route_sync (
            .clk       (clk),
            .reset     (reset),
            .pin_in    (low_line_routing_strap[gi]),
            .level_out (rsync)
         );
         assign route_sync[gi] = rsync;
         // Each line has its own strap and router
         dorr_low_router u_router (
            .clk        (clk),
            .reset      (reset),
            .line_in    (dout_reg[gi]),
            .route_alt  (rsync),
            .header_out (hdr_low[gi]),
            .main_out   (main_connector_37pin[gi])
         );
      end
   endgenerate

   // Host bus reset clears only in factory strap position
   assign busrst_clear = busrst_sync && (keep_sync != dorr_pkg::DORR_KEEP_SEL);
   assign wr_data      = wr && (addr == dorr_pkg::DORR_ADDR_DATA) && !busrst_sync;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dorr_pkg::DORR_ST_POWERUP: state_next = dorr_pkg::DORR_ST_RUN;
         dorr_pkg::DORR_ST_RUN: begin
            if (busrst_sync) begin
               state_next = dorr_pkg::DORR_ST_BUSRST;
            end
         end
         dorr_pkg::DORR_ST_BUSRST: begin
            if (!busrst_sync) begin
               state_next = dorr_pkg::DORR_ST_RUN;
            end
         end
         default: state_next = dorr_pkg::DORR_ST_POWERUP;
      endcase
   end

   // Writes ignored while bus reset is active; keep mode holds last value
   assign dout_next = busrst_clear ? dorr_pkg::DORR_OFF_VALUE[LINES-1:0] :
                      wr_data      ? wdata[LINES-1:0] :
                                     dout_reg;

   assign strap_status = {{(16-dorr_pkg::DORR_ST_ROUTE-LOW_LINES){1'b0}}, route_sync,
                          {(dorr_pkg::DORR_ST_ROUTE-1){1'b0}}, keep_sync};

   assign rdata_next = !rd                                ? 16'h0000 :
                       (addr == dorr_pkg::DORR_ADDR_DATA)  ? 16'(dout_reg) :
                       (addr == dorr_pkg::DORR_ADDR_STRAP) ? strap_status :
                       (addr == dorr_pkg::DORR_ADDR_ROUTE) ? {12'h000, route_sync} :
                                                            16'h0000;

   assign hdr_next = {dout_reg[LINES-1:LOW_LINES], {LOW_LINES{1'b0}}};

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= dorr_pkg::DORR_ST_POWERUP;
         dout_reg  <= '0;
         rdata_reg <= 16'h0000;
         hdr_reg   <= '0;
      end else begin
         state_reg <= state_next;
         dout_reg  <= dout_next;
         rdata_reg <= rdata_next;
         hdr_reg   <= hdr_next;
      end
   end

   assign rdata               = rdata_reg;
   assign output_header_20pin = {hdr_reg[LINES-1:LOW_LINES], hdr_low};
   // Daughterboard decodes these as binary channel code; they follow output lines 0 to 3 whatever the routing straps
   assign mux_select_line_0   = dout_reg[0];
   assign mux_select_line_1   = dout_reg[1];
   assign mux_select_line_2   = dout_reg[2];
   assign mux_select_line_3   = dout_reg[3];

   AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (reset)
      wr_data && !busrst_clear |=> dout_reg == $past(wdata))
      else $error("Output write not taken");
   AST_KEEP_HOLDS: assert property (@(posedge clk) disable iff (reset)
      busrst_sync && keep_sync |=> dout_reg == $past(dout_reg))
      else $error("Outputs changed under bus reset in keep mode");
   AST_FACTORY_CLEARS: assert property (@(posedge clk) disable iff (reset)
      busrst_sync && !keep_sync |=> dout_reg == '0)
      else $error("Outputs not cleared on bus reset");
   AST_POWERON_OFF: assert property (@(posedge clk)
      $past(reset) |-> dout_reg == '0 && main_connector_37pin == '0)
      else $error("Outputs not off after power-on reset");
   AST_HDR_ROUTE: assert property (@(posedge clk) disable iff (reset)
      !route_sync[0] ##1 !route_sync[0] |-> output_header_20pin[0] == $past(dout_reg[0]))
      else $error("Header line 0 not following output");
   AST_MAIN_ROUTE: assert property (@(posedge clk) disable iff (reset)
      route_sync[1] ##1 route_sync[1] |-> main_connector_37pin[1] == $past(dout_reg[1])
         && output_header_20pin[1] == 1'b0)
      else $error("Main connector line 1 misrouted");
   AST_ROUTE_INDEP: assert property (@(posedge clk) disable iff (reset)
      route_sync[2] && !route_sync[3] ##1 1'b1 |-> output_header_20pin[2] == 1'b0
         && main_connector_37pin[3] == 1'b0)
      else $error("Routing straps not independent");
   AST_READ_DATA: assert property (@(posedge clk) disable iff (reset)
      rd && addr == dorr_pkg::DORR_ADDR_DATA |=> rdata == 16'($past(dout_reg)))
      else $error("Output read data wrong");
   AST_HDR_HIGH: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> output_header_20pin[LINES-1:LOW_LINES] == $past(dout_reg[LINES-1:LOW_LINES]))
      else $error("High header lines not following outputs");
   AST_ONE_CONNECTOR: assert property (@(posedge clk) disable iff (reset)
      (main_connector_37pin & output_header_20pin[LOW_LINES-1:0]) == '0)
      else $error("Low line driven on both connectors");
   AST_IDLE_RDATA: assert property (@(posedge clk) disable iff (reset)
      !rd |=> rdata == 16'h0000)
      else $error("Read data not idle without a read");
   AST_STRAP_READ: assert property (@(posedge clk) disable iff (reset)
      rd && addr == dorr_pkg::DORR_ADDR_STRAP |=> rdata[dorr_pkg::DORR_ST_KEEP] == $past(keep_sync))
      else $error("Retention strap status read wrong");
   AST_ROUTE_READ: assert property (@(posedge clk) disable iff (reset)
      rd && addr == dorr_pkg::DORR_ADDR_ROUTE |=> rdata[LOW_LINES-1:0] == $past(route_sync))
      else $error("Routing strap read wrong");
   // Retained outputs carry on once a keep-mode bus reset ends
   COV_RESTORE: cover property (@(posedge clk) busrst_sync && keep_sync ##1 !busrst_sync);
   COV_HDR: cover property (@(posedge clk) !route_sync[0] && output_header_20pin[0]);
   COV_KEEP: cover property (@(posedge clk) busrst_sync && keep_sync && dout_reg != '0);
   COV_CLEAR: cover property (@(posedge clk) busrst_sync && !keep_sync ##1 dout_reg == '0);
   COV_ALT: cover property (@(posedge clk) route_sync[0] && main_connector_37pin[0]);
endmodule : dorr_port
`default_nettype wire

// *** shared/dorr_pkg.sv ***
// Constants and types for the digital output port with reset routing
// Summary of operation
// - Sixteen separately driven output lines, numbered from zero, TTL levels.
// - Retention strap in keep position holds outputs across a host bus reset.
// - Retention strap in factory position clears outputs on a host bus reset.
// - Power-on reset always clears outputs, whatever the retention strap says.
// - Each of lines 0 to 3 routes independently by its own routing strap.
// - Routing strap in factory position drives the line on the 20-pin header.
// - Routing strap in alternate position drives the line on the 37-pin connector.
`default_nettype none
package dorr_pkg;
   localparam int          DORR_LINES      = 16;
   localparam int          DORR_LOW_LINES  = 4;
   localparam int          DORR_ADDR_W     = 4;
   localparam logic [15:0] DORR_OFF_VALUE  = 16'h0000;
   localparam logic [3:0]  DORR_OFF_LOW    = 4'h0;
   // Register indices
   localparam logic [3:0]  DORR_ADDR_DATA  = 4'h0;
   localparam logic [3:0]  DORR_ADDR_STRAP = 4'h1;
   localparam logic [3:0]  DORR_ADDR_ROUTE = 4'h2;
   // Strap status field positions
   localparam int          DORR_ST_KEEP    = 0;
   localparam int          DORR_ST_ROUTE   = 4;
   // Strap level meaning
   localparam logic        DORR_KEEP_SEL   = 1'b1;
   localparam logic        DORR_ROUTE_ALT  = 1'b1;
   localparam logic [1:0]  DORR_SYNC_ONES  = 2'h3;
   typedef enum logic [1:0] {
      DORR_ST_POWERUP = 2'b00,
      DORR_ST_RUN     = 2'b01,
      DORR_ST_BUSRST  = 2'b10
   } dorr_state_e;
endpackage : dorr_pkg
`default_nettype wire

// *** design/dorr_strap_sync.sv ***
// Three-flop synchroniser with agreement filter for a strap pin
`default_nettype none
module dorr_strap_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic pin_in,
   output logic      level_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   logic level_next;

   // Only the later two stages are compared; first stage may be metastable
   assign level_next = (s2_reg == s3_reg) ? s2_reg : level_reg;
   assign level_out  = level_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_reg    <= INIT;
         s2_reg    <= INIT;
         s3_reg    <= INIT;
         level_reg <= INIT;
      end else begin
         s1_reg    <= pin_in;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end
endmodule : dorr_strap_sync
`default_nettype wire

// *** design/dorr_low_router.sv ***
// Routes one low-order output line to header or main connector
`default_nettype none
module dorr_low_router (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic line_in,
   input  wire logic route_alt,
   output logic      header_out,
   output logic      main_out
);
   logic header_next;
   logic main_next;
   logic header_reg;
   logic main_reg;

   // Unselected connector idles at off
   assign header_next = (route_alt != dorr_pkg::DORR_ROUTE_ALT) ? line_in : 1'b0;
   assign main_next   = (route_alt == dorr_pkg::DORR_ROUTE_ALT) ? line_in : 1'b0;
   assign header_out  = header_reg;
   assign main_out    = main_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         header_reg <= 1'b0;
         main_reg   <= 1'b0;
      end else begin
         header_reg <= header_next;
         main_reg   <= main_next;
      end
   end
endmodule : dorr_low_router
`default_nettype wire

// *** testbench/dorr_mux_model.sv ***
// Behavioural multiplexer daughterboard reading the four select lines
`default_nettype none
module dorr_mux_model (
   input  wire logic clk,
   input  wire logic sel_0,
   input  wire logic sel_1,
   input  wire logic sel_2,
   input  wire logic sel_3,
   output int        chan
);
   timeunit 1ns;
   timeprecision 1ps;
   // Binary code, line 0 least significant; latched per clock like a real analog switch
   always @(posedge clk) begin
      chan <= int'({sel_3, sel_2, sel_1, sel_0});
   end
endmodule : dorr_mux_model
`default_nettype wire

// *** testbench/tb_dorr_port.sv ***
// Self-checking bench for the sixteen-line output port
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb_dorr_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        reset, bus_reset, keep, wr, rd, m0, m1, m2, m3;
   logic [3:0]  route, addr, main;
   logic [15:0] wdata, rdata, header;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          chan, m_dout, m_route;
   logic [31:0] seed = 32'h0000c3ee;
   always #2.5 clk = ~clk;
   dorr_port dut_u (.clk(clk), .reset(reset), .bus_reset(bus_reset), .output_retention_strap(keep),
      .low_line_routing_strap(route), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .output_header_20pin(header), .main_connector_37pin(main), .mux_select_line_0(m0),
      .mux_select_line_1(m1), .mux_select_line_2(m2), .mux_select_line_3(m3));
   dorr_mux_model mux_u (.clk(clk), .sel_0(m0), .sel_1(m1), .sel_2(m2), .sel_3(m3), .chan(chan));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask : rd_reg
   task automatic chk_pins();
      logic [15:0] e;
      logic [3:0]  r;
      e = m_dout[15:0];
      r = m_route[3:0];
      #1;
      `CHK("header", {e[15:4], e[3:0] & ~r}, header)
      `CHK("main", e[3:0] & r, main)
      `CHK("mux_sel", e[3:0], {m3, m2, m1, m0})
      `CHK("chan", e[3:0], chan[3:0])
   endtask : chk_pins
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   initial begin
      // Whole run is well under 2000 cycles
      #(20000 * 5);
      n_errors++;
      end_of_test();
   end
   initial begin
      logic [31:0] v;
      reset = 1'b1;
      bus_reset = 1'b0;
      keep = 1'b0;
      route = 4'h0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      m_dout = 0;
      m_route = 0;
      cyc(12);
      reset <= 1'b0;
      // Random data with every routing pattern corner and random ones
      for (int i = 0; i < 10; i++) begin
         v = xs();
         m_route = (i == 0) ? 0 : (i == 1) ? 15 : v[19:16];
         route <= m_route[3:0];
         cyc(8);
         m_dout = v[15:0];
         wr_reg(dorr_pkg::DORR_ADDR_DATA, v[15:0]);
         cyc(1);
         chk_pins();
         rd_reg(dorr_pkg::DORR_ADDR_DATA, m_dout[15:0]);
      end
      // Read-only and unmapped places
      wr_reg(dorr_pkg::DORR_ADDR_STRAP, 16'hffff);
      rd_reg(dorr_pkg::DORR_ADDR_STRAP, {8'h00, m_route[3:0], 3'h0, keep});
      wr_reg(dorr_pkg::DORR_ADDR_ROUTE, 16'hffff);
      rd_reg(dorr_pkg::DORR_ADDR_ROUTE, {12'h000, m_route[3:0]});
      wr_reg(4'h7, 16'h1234);
      rd_reg(4'h7, 16'h0000);
      rd_reg(dorr_pkg::DORR_ADDR_DATA, m_dout[15:0]);
      // Host bus reset, factory then keep position; a write inside it is dropped
      for (int k = 0; k < 2; k++) begin
         keep <= k[0];
         v = xs();
         m_dout = v[15:0];
         wr_reg(dorr_pkg::DORR_ADDR_DATA, v[15:0]);
         cyc(8);
         bus_reset <= 1'b1;
         cyc(8);
         wr_reg(dorr_pkg::DORR_ADDR_DATA, ~v[15:0]);
         cyc(3);
         if (k == 0) m_dout = 0;
         chk_pins();
         bus_reset <= 1'b0;
         cyc(8);
         chk_pins();
         rd_reg(dorr_pkg::DORR_ADDR_DATA, m_dout[15:0]);
      end
      // Power-on reset clears even with the keep strap set
      reset <= 1'b1;
      cyc(3);
      reset <= 1'b0;
      m_dout = 0;
      cyc(1);
      chk_pins();
      rd_reg(dorr_pkg::DORR_ADDR_DATA, 16'h0000);
      end_of_test();
   end
endmodule : tb_dorr_port
`default_nettype wire
